// File: hdl/adc_frame_pkg.sv
// constants, field layout and state codes of the serial frame sequencer
package adc_frame_pkg;
    localparam int CTRL_W = 7;
    localparam int RES_W = 12;
    localparam int EVT_W = 3;
    // control byte fields after the start bit, msb first
    localparam int CHANNEL_SELECT_HI = 6;
    localparam int CHANNEL_SELECT_MID = 5;
    localparam int CHANNEL_SELECT_LO = 4;
    localparam int POLARITY_BIT = 3;
    localparam int INPUT_MODE_BIT = 2;
    localparam int POWER_MODE_HI = 1;
    localparam int POWER_MODE_LO = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
    // conversion step counter, advanced on sclk falling edges
    localparam logic [3:0] STEP_IDLE = 4'h0;
    localparam logic [3:0] STEP_STROBE = 4'h1;
    localparam logic [3:0] STEP_FIRST_BIT = 4'h3;
    localparam logic [3:0] STEP_OPEN = 4'h9;
    localparam logic [3:0] STEP_LAST_BIT = 4'hE;
    localparam logic [3:0] STEP_DONE = 4'hF;
    localparam logic [3:0] MSB_INDEX = 4'hB;
    localparam logic [2:0] RX_LAST = 3'h6;
    localparam logic [RES_W-1:0] TRIAL_START = 12'h800;
    // event toggle positions
    localparam int EVT_START = 0;
    localparam int EVT_DONE = 1;
    localparam int EVT_ABORT = 2;
    // hold time limit on the system clock
    localparam int HOLD_LIMIT_US = 120;
    localparam int CLOCK_KHZ = 25000;
    localparam logic [11:0] HOLD_LIMIT_CYC =
        12'((HOLD_LIMIT_US * CLOCK_KHZ) / 1000);
    localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b01,
        RX_BYTE = 2'b10
    } rx_state_e;

    // {positive input, negative input, negative is common}
    function automatic logic [6:0] channel_pair(input logic [2:0] sel,
                                               input logic single);
        logic [2:0] pos;
        logic [2:0] neg;
        pos = {sel[1:0], sel[2]};
        neg = single ? 3'h0 : {sel[1:0], ~sel[2]};
        return {pos, neg, single};
    endfunction
endpackage

// File: hdl/link_status_if.sv
// words and event toggles passed from the link domain to the system side
`timescale 1ns/1ps
`default_nettype none
interface link_status_if;
    logic [adc_frame_pkg::CTRL_W-1:0] ctrl;
    logic [adc_frame_pkg::RES_W-1:0] result;
    logic [adc_frame_pkg::EVT_W-1:0] evt_toggle;
    modport link (output ctrl, output result, output evt_toggle);
    modport core (input ctrl, input result, input evt_toggle);
endinterface
`default_nettype wire

// File: hdl/status_bridge.sv
// system clock side of the link crossing: status capture and hold timer
`timescale 1ns/1ps
`default_nettype none
module status_bridge (
    // system
    input wire logic clock,
    input wire logic reset,
    // from the link domain
    link_status_if.core lnk,
    // status
    output logic [1:0] power_mode,
    output logic polarity_select,
    output logic input_mode_select,
    output logic [adc_frame_pkg::RES_W-1:0] result_code,
    output logic result_valid,
    output logic converting,
    output logic hold_overrun,
    output logic conversion_aborted
);
    import adc_frame_pkg::*;

    logic [EVT_W-1:0] s1_q, s2_q, s3_q, seen_q, evt;
    logic [11:0] hold_cnt_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= lnk.evt_toggle;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a toggle counts once the second and third stages agree
    for (genvar i = 0; i < EVT_W; i++) begin : g_evt
        assign evt[i] = (s2_q[i] == s3_q[i]) && (s3_q[i] != seen_q[i]);
        always_ff @(posedge clock) begin
            if (reset) begin
                seen_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                seen_q[i] <= s3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            power_mode <= 2'h0;
            polarity_select <= 1'b0;
            input_mode_select <= 1'b0;
            result_code <= '0;
            result_valid <= 1'b0;
            converting <= 1'b0;
            conversion_aborted <= 1'b0;
        end else begin
            result_valid <= evt[EVT_DONE];
            conversion_aborted <= evt[EVT_ABORT];
            // a new start in the same cycle as a done keeps us busy
            converting <= evt[EVT_START] |
                (converting & ~evt[EVT_DONE] & ~evt[EVT_ABORT]);
            if (evt[EVT_START]) begin
                power_mode <= lnk.ctrl[POWER_MODE_HI:POWER_MODE_LO];
                polarity_select <= lnk.ctrl[POLARITY_BIT];
                input_mode_select <= lnk.ctrl[INPUT_MODE_BIT];
            end
            if (evt[EVT_DONE]) begin
                result_code <= lnk.result;
            end
        end
    end

    // flags a conversion held longer than the sample can stand
    always_ff @(posedge clock) begin
        if (reset || evt[EVT_START]) begin
            hold_cnt_q <= 12'h000;
            hold_overrun <= 1'b0;
        end else if (converting) begin
            if (hold_cnt_q != HOLD_LIMIT_CYC) begin
                hold_cnt_q <= hold_cnt_q + 12'h001;
            end else begin
                hold_overrun <= 1'b1;
            end
        end
    end

    property valid_one_cycle;
        @(posedge clock) disable iff (reset)
        result_valid |=> !result_valid || $past(evt[EVT_DONE]);
    endproperty
    valid_pulse_a: assert property (valid_one_cycle)
        else $error("result valid held without a new done event");

    property overrun_bound;
        @(posedge clock) disable iff (reset)
        (converting && !evt[EVT_START] && hold_cnt_q == HOLD_LIMIT_CYC)
            |=> hold_overrun;
    endproperty
    hold_overrun_a: assert property (overrun_bound)
        else $error("hold overrun not flagged at the time limit");
endmodule
`default_nettype wire

// File: hdl/adc_serial_frame_sequencer.sv
// serial frame sequencer: control byte receive, strobe and sar bit output
//
// Contract
// - strobe high for exactly one sclk period after the last control bit
// - one result bit decided and shown on each of twelve falling edges
// - chip select high floats strobe and data out; strobe then reads low
// - select falling starts nothing; first high input bit is the start
// - conversion begins on the falling edge after the eighth control bit
// - while idle, first high bit with chip select low is the start bit
// - during conversion, a start is taken after result bit 6 is out
// - once started, only hardware shutdown aborts the conversion
// - back-to-back conversions are no closer than 16 sclk cycles
// - pseudo-differential low select bits pick pairs 0/1, 2/3, 4/5, 6/7
// - data in is sampled on each rising sclk edge while select is low
// - byte is start, three select, polarity, input mode, two power bits
// - result msb first; plain binary unipolar, two's complement bipolar
// - two-byte read shows three leading zeros and one trailing zero
`timescale 1ns/1ps
`default_nettype none
module adc_serial_frame_sequencer (
    // system
    input wire logic clock,
    input wire logic reset,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe_out,
    output logic strobe_oe,
    input wire logic hardware_shutdown_n,
    // analog core
    input wire logic comparator_above,
    output logic [adc_frame_pkg::RES_W-1:0] trial_code,
    output logic sample_hold,
    output logic [2:0] positive_input,
    output logic [2:0] negative_input,
    output logic negative_is_common,
    // status
    output logic [1:0] power_mode,
    output logic polarity_select,
    output logic input_mode_select,
    output logic [adc_frame_pkg::RES_W-1:0] result_code,
    output logic result_valid,
    output logic converting,
    output logic hold_overrun,
    output logic conversion_aborted
);
    import adc_frame_pkg::*;

    logic [2:0] lrst_sync_q, hardware_shutdown_n_sync_q, cs_sync_q;
    logic link_rst_q, abort_q, oe_q;
    rx_state_e rx_q;
    logic [2:0] rx_cnt_q;
    logic [CTRL_W-1:0] rx_shift_q, run_ctrl_q;
    logic frame_go_q, strobe_q, dout_q, start_open, out_bit, bipolar;
    logic [3:0] step_q, bit_idx;
    logic [RES_W-1:0] trial_q, trial_d, result_q;
    logic [EVT_W-1:0] evt_q;
    logic [6:0] pair;

    // reset and shutdown carried into the link domain
    // note: the link side only resets or aborts while sclk is running
    always_ff @(posedge sclk) begin
        lrst_sync_q <= {lrst_sync_q[1:0], reset};
        link_rst_q <= lrst_sync_q[1] & lrst_sync_q[2];
        hardware_shutdown_n_sync_q <= {hardware_shutdown_n_sync_q[1:0], hardware_shutdown_n};
        abort_q <= ~hardware_shutdown_n_sync_q[1] & ~hardware_shutdown_n_sync_q[2];
    end

    // output enables follow chip select on the free running clock,
    // since sclk may stand still once select goes high
    always_ff @(posedge clock) begin
        if (reset) begin
            cs_sync_q <= SYNC_IDLE_HIGH;
            oe_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                oe_q <= ~cs_sync_q[2];
            end
        end
    end

    assign start_open = (step_q == STEP_IDLE) || (step_q >= STEP_OPEN);

    // control byte receiver on rising sclk
    always_ff @(posedge sclk) begin
        if (link_rst_q || abort_q) begin
            rx_q <= RX_HUNT;
            rx_cnt_q <= 3'h0;
            rx_shift_q <= CTRL_RESET;
            frame_go_q <= 1'b0;
        end else begin
            frame_go_q <= 1'b0;
            if (!cs_n) begin
                case (rx_q)
                    RX_HUNT: begin
                        // zeros are ignored until a high bit arrives
                        if (din && start_open) begin
                            rx_q <= RX_BYTE;
                            rx_cnt_q <= 3'h0;
                        end
                    end
                    RX_BYTE: begin
                        rx_shift_q <= {rx_shift_q[CTRL_W-2:0], din};
                        rx_cnt_q <= rx_cnt_q + 3'h1;
                        if (rx_cnt_q == RX_LAST) begin
                            rx_q <= RX_HUNT;
                            frame_go_q <= 1'b1;
                        end
                    end
                    default: begin
                        rx_q <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    assign bit_idx = 4'(STEP_LAST_BIT - step_q);
    assign bipolar = ~run_ctrl_q[POLARITY_BIT];
    assign out_bit = comparator_above ^ (bipolar && bit_idx == MSB_INDEX);
    assign pair = channel_pair(rx_shift_q[CHANNEL_SELECT_HI:CHANNEL_SELECT_LO],
                               rx_shift_q[INPUT_MODE_BIT]);

    always_comb begin
        trial_d = trial_q;
        trial_d[bit_idx] = comparator_above;
        if (bit_idx != 4'h0) begin
            trial_d[4'(bit_idx - 4'h1)] = 1'b1;
        end
    end

    // conversion sequencer on falling sclk
    always_ff @(negedge sclk) begin
        if (link_rst_q || abort_q) begin
            step_q <= STEP_IDLE;
            strobe_q <= 1'b0;
            dout_q <= 1'b0;
            trial_q <= '0;
            sample_hold <= 1'b0;
        end else if (frame_go_q) begin
            step_q <= STEP_STROBE;
            strobe_q <= 1'b1;
            dout_q <= 1'b0;
            trial_q <= TRIAL_START;
            sample_hold <= 1'b1;
        end else begin
            strobe_q <= 1'b0;
            if (step_q >= STEP_FIRST_BIT && step_q <= STEP_LAST_BIT) begin
                dout_q <= out_bit;
                trial_q <= trial_d;
            end else begin
                dout_q <= 1'b0;
            end
            if (step_q == STEP_DONE) begin
                step_q <= STEP_IDLE;
                sample_hold <= 1'b0;
            end else if (step_q != STEP_IDLE) begin
                step_q <= step_q + 4'h1;
            end
        end
    end

    // settings are frozen at conversion start so a following byte
    // cannot disturb the bits still being resolved
    always_ff @(negedge sclk) begin
        if (link_rst_q) begin
            run_ctrl_q <= CTRL_RESET;
            positive_input <= 3'h0;
            negative_input <= 3'h0;
            negative_is_common <= 1'b0;
        end else if (frame_go_q && !abort_q) begin
            run_ctrl_q <= rx_shift_q;
            positive_input <= pair[6:4];
            negative_input <= pair[3:1];
            negative_is_common <= pair[0];
        end
    end

    always_ff @(negedge sclk) begin
        if (link_rst_q) begin
            result_q <= '0;
        end else if (!abort_q && step_q >= STEP_FIRST_BIT &&
                     step_q <= STEP_LAST_BIT) begin
            result_q[bit_idx] <= out_bit;
        end
    end

    always_ff @(negedge sclk) begin
        if (link_rst_q) begin
            evt_q <= '0;
        end else if (abort_q) begin
            if (step_q != STEP_IDLE) begin
                evt_q[EVT_ABORT] <= ~evt_q[EVT_ABORT];
            end
        end else if (frame_go_q) begin
            evt_q[EVT_START] <= ~evt_q[EVT_START];
        end else if (step_q == STEP_LAST_BIT) begin
            evt_q[EVT_DONE] <= ~evt_q[EVT_DONE];
        end
    end

    assign dout = dout_q;
    assign conversion_strobe_out = strobe_q;
    assign dout_oe = oe_q;
    assign strobe_oe = oe_q;
    assign trial_code = trial_q;

    link_status_if lnk ();
    assign lnk.ctrl = run_ctrl_q;
    assign lnk.result = result_q;
    assign lnk.evt_toggle = evt_q;

    status_bridge u_bridge (
        .clock(clock),
        .reset(reset),
        .lnk(lnk),
        .power_mode(power_mode),
        .polarity_select(polarity_select),
        .input_mode_select(input_mode_select),
        .result_code(result_code),
        .result_valid(result_valid),
        .converting(converting),
        .hold_overrun(hold_overrun),
        .conversion_aborted(conversion_aborted)
    );

    sequence strobe_pulse;
        strobe_q ##1 !strobe_q;
    endsequence

    sequence quiet_frame;
        (!strobe_q)[*8] ##1 (!strobe_q)[*7];
    endsequence

    strobe_width_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        $rose(strobe_q) |-> strobe_pulse)
        else $error("strobe not exactly one sclk period");

    start_edge_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        frame_go_q |=> strobe_q && step_q == STEP_STROBE)
        else $error("conversion did not start after the eighth bit");

    result_span_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        strobe_q |-> ##14 step_q == STEP_DONE)
        else $error("twelve result bits not finished on time");

    msb_coding_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        step_q == STEP_FIRST_BIT |=>
            dout_q == ($past(comparator_above) ^ bipolar))
        else $error("msb coding wrong for selected polarity");

    pad_zeros_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        (step_q == STEP_STROBE || step_q == STEP_DONE) |=> !dout_q)
        else $error("pad bit around result is not zero");

    frame_spacing_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        $rose(strobe_q) |=> quiet_frame)
        else $error("conversions closer than sixteen clocks");

    start_gate_a: assert property (
        @(posedge sclk) disable iff (link_rst_q || abort_q)
        (rx_q == RX_HUNT && !cs_n && din && !start_open) |=> rx_q == RX_HUNT)
        else $error("start bit taken before result bit six");

    idle_start_a: assert property (
        @(posedge sclk) disable iff (link_rst_q || abort_q)
        (rx_q == RX_HUNT && !cs_n && din && step_q == STEP_IDLE)
            |=> rx_q == RX_BYTE ##7 frame_go_q)
        else $error("idle start bit not taken as control byte msb");

    pair_decode_a: assert property (
        @(negedge sclk) disable iff (link_rst_q || abort_q)
        (frame_go_q && !rx_shift_q[INPUT_MODE_BIT]) |=>
            positive_input[2:1] == negative_input[2:1] &&
            positive_input[0] == run_ctrl_q[CHANNEL_SELECT_HI] &&
            negative_input[0] != positive_input[0])
        else $error("pseudo-differential pair decoded wrongly");

    shutdown_stop_a: assert property (
        @(negedge sclk) disable iff (link_rst_q)
        abort_q |=> step_q == STEP_IDLE && !strobe_q)
        else $error("shutdown did not stop the conversion");

    select_float_a: assert property (
        @(posedge clock) disable iff (reset)
        (cs_sync_q[1] && cs_sync_q[2]) |=> !dout_oe && !strobe_oe)
        else $error("outputs driven with chip select high");
endmodule
`default_nettype wire

// File: verification/serial_master_model.sv
// serial bus master model: frames control bytes and reads the result pins
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
    // pins driven by the master
    output logic sclk,
    output logic cs_n,
    output logic din,
    output logic shutdown_n,
    // pins read back
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic strobe,
    input wire logic strobe_oe
);
    localparam int HALF = 6;
    logic [63:0] rx;
    logic [63:0] stb;
    logic last_dout;
    logic last_stb;
    logic dout_pin;
    logic stb_pin;
    int idx;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        shutdown_n = 1'b1;
        last_dout = 1'b0;
        last_stb = 1'b0;
        rx = '0;
        stb = '0;
        idx = 0;
    end

    // a released pin shows the inverse of its last value, never a kind one
    assign dout_pin = dout_oe ? dout : ~last_dout;
    assign stb_pin = strobe_oe ? strobe : ~last_stb;
    always @(posedge sclk) begin
        if (dout_oe) last_dout <= dout;
        if (strobe_oe) last_stb <= strobe;
    end

    task automatic clear();
        rx = '0;
        stb = '0;
        idx = 0;
    endtask

    task automatic select(input logic lvl);
        cs_n = lvl;
    endtask

    // free clocking with select high, used only around reset
    task automatic idle(input int n);
        repeat (n) begin
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
    endtask

    // sclk stands still between calls; shutdown pulled low for 3 bits at sd_at
    task automatic shift(input int n, input logic [63:0] tx, input int sd_at);
        for (int i = 0; i < n; i++) begin
            din = tx[n-1-i];
            shutdown_n = !(sd_at > 0 && idx >= sd_at && idx < sd_at + 3);
            #HALF;
            idx++;
            rx[idx] = dout_pin;
            stb[idx] = stb_pin;
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
        shutdown_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the serial frame sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin num_checks++; \
    if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
    import adc_frame_pkg::*;
    logic clock;
    logic reset;
    logic sclk;
    logic cs_n;
    logic din;
    logic shutdown_n;
    logic dout;
    logic dout_oe;
    logic conversion_strobe_out;
    logic strobe_oe;
    logic comparator_above;
    logic [RES_W-1:0] trial_code;
    logic sample_hold;
    logic [2:0] positive_input;
    logic [2:0] negative_input;
    logic negative_is_common;
    logic [1:0] power_mode;
    logic polarity_select;
    logic input_mode_select;
    logic [RES_W-1:0] result_code;
    logic result_valid;
    logic converting;
    logic hold_overrun;
    logic conversion_aborted;
    logic [11:0] level;
    logic aborted_seen = 1'b0;
    int valid_cnt = 0;
    logic [3:0] cfg_out;
    logic [6:0] mux_out;
    int err_count;
    int num_checks;

    // ideal comparator: analog input held at level
    assign comparator_above = (trial_code <= level);

    adc_serial_frame_sequencer dut_u (
        .clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe),
        .conversion_strobe_out(conversion_strobe_out),
        .strobe_oe(strobe_oe), .hardware_shutdown_n(shutdown_n),
        .comparator_above(comparator_above), .trial_code(trial_code),
        .sample_hold(sample_hold), .positive_input(positive_input),
        .negative_input(negative_input),
        .negative_is_common(negative_is_common), .power_mode(power_mode),
        .polarity_select(polarity_select),
        .input_mode_select(input_mode_select), .result_code(result_code),
        .result_valid(result_valid), .converting(converting),
        .hold_overrun(hold_overrun), .conversion_aborted(conversion_aborted)
    );

    serial_master_model m_u (
        .sclk(sclk), .cs_n(cs_n), .din(din), .shutdown_n(shutdown_n),
        .dout(dout), .dout_oe(dout_oe), .strobe(conversion_strobe_out),
        .strobe_oe(strobe_oe)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    assign cfg_out = {power_mode, polarity_select, input_mode_select};
    assign mux_out = {positive_input, negative_input, negative_is_common};

    always @(posedge clock) begin
        if (conversion_aborted === 1'b1) aborted_seen <= 1'b1;
    end

    // every result_valid pulse is counted, one per finished conversion
    always @(posedge clock) begin
        if (result_valid === 1'b1) valid_cnt <= valid_cnt + 1;
    end

    task automatic clocks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic logic [15:0] rd16(input int s);
        logic [15:0] w;
        for (int k = 0; k < 16; k++) w[15-k] = m_u.rx[s+k];
        return w;
    endfunction

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one complete frame after pre leading zeros, then result, valid count, settings, mux and busy flags compared
    task automatic run(input int pre, input logic [7:0] c);
        logic [11:0] code;
        logic [6:0] mux;
        logic [3:0] cfg;
        int vld;
        code = c[3] ? level : level ^ 12'h800;
        mux = c[2] ? {c[5:4], c[6], 4'h1} :
            {c[5:4], c[6], c[5:4], ~c[6], 1'b0};
        cfg = {c[1:0], c[3], c[2]};
        vld = valid_cnt;
        m_u.clear();
        m_u.shift(pre + 24, {40'h0, c, 16'h0}, 0);
        `CHECK(m_u.stb, (64'h1 << (pre + 9)))
        `CHECK(rd16(pre + 9), ({3'h0, code, 1'h0}))
        clocks(12);
        `CHECK(result_code, code)
        `CHECK(valid_cnt, (vld + 1))
        `CHECK(cfg_out, cfg)
        `CHECK(mux_out, mux)
        `CHECK(({converting, sample_hold}), 2'b00)
    endtask

    initial begin
        #2000000;
        err_count++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        level = 12'h000;
        err_count = 0;
        num_checks = 0;
        // link side needs sclk edges while reset is held
        fork
            repeat (16) @(posedge clock);
            m_u.idle(30);
        join
        #1 reset = 1'b0;
        m_u.idle(8);
        clocks(6);
        `CHECK(({dout_oe, strobe_oe}), 2'b00)
        m_u.select(1'b0);
        clocks(10);
        `CHECK(({strobe_oe, conversion_strobe_out}), 2'b10)
        `CHECK(converting, 1'b0)
        for (int i = 0; i < 10; i++) begin
            level = 12'h0A5 + 12'(i) * 12'h1F3;
            run(i == 0 ? 16 : i, {1'b1, 3'(i), i[1], 1'(i > 7), i[1:0]});
        end
        // overlapped frames at 16 clocks each
        level = 12'h3C6;
        m_u.clear();
        m_u.shift(40, {24'h0, 8'hBB, 8'h0, 8'h9F, 16'h0}, 0);
        `CHECK(m_u.stb, ((64'h1 << 9) | (64'h1 << 25)))
        `CHECK(rd16(25), ({3'h0, level, 1'h0}))
        clocks(12);
        `CHECK(({positive_input, negative_is_common}), 4'h5)
        // a high bit before result bit 6 is out must not restart
        m_u.clear();
        m_u.shift(24, {40'h0, 8'hBB, 16'h0800}, 0);
        `CHECK(m_u.stb, (64'h1 << 9))
        `CHECK(rd16(9), ({3'h0, level, 1'h0}))
        // master stalls mid conversion past the hold limit
        m_u.clear();
        m_u.shift(12, {52'h0, 8'hBB, 4'h0}, 0);
        clocks(2900);
        `CHECK(({converting, hold_overrun}), 2'b10)
        clocks(200);
        `CHECK(hold_overrun, 1'b1)
        m_u.shift(12, 64'h0, 0);
        clocks(12);
        `CHECK(({converting, rd16(9)}), ({1'b0, 3'h0, level, 1'h0}))
        // shutdown in mid conversion is the only abort
        m_u.clear();
        m_u.shift(24, {40'h0, 8'hBB, 16'h0}, 14);
        clocks(12);
        `CHECK(({aborted_seen, converting, sample_hold}), 3'b100)
        level = 12'hFFF;
        run(0, 8'h8C);
        m_u.select(1'b1);
        clocks(8);
        `CHECK(({dout_oe, strobe_oe}), 2'b00)
        `CHECK(conversion_strobe_out, 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
